// File: backup_power_pkg.sv
// Constants and carrier types for the backup power mode control block
package backup_power_pkg;
	localparam int ADDR_W = 10;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 10'h014;
	localparam logic [ADDR_W-1:0] OFF_UNLOCK = 10'h018;
	localparam logic [ADDR_W-1:0] OFF_POWER_MODE_CONTROL = 10'h01c;
	localparam logic [ADDR_W-1:0] OFF_WAKE_CAUSE = 10'h028;
	localparam logic [ADDR_W-1:0] OFF_WAKE_EN = 10'h02c;
	localparam logic [ADDR_W-1:0] OFF_PAD_ROUTE = 10'h030;
	localparam logic [ADDR_W-1:0] OFF_IO_HOLD = 10'h034;
	localparam logic [ADDR_W-1:0] OFF_REVISION = 10'h0fc;
	localparam logic [7:0] UNLOCK_KEY = 8'haa;
	localparam int KEY_LSB = 24;
	localparam int ERR_BIT = 31;
	localparam int PS_LSB = 0;
	localparam int SCALING_CHANGE_REQUEST_BIT = 2;
	localparam int BACKUP_MODE_SELECT_BIT = 8;
	localparam int RET_BIT = 9;
	localparam int SLEEP_LSB = 12;
	localparam int LOW_SPEED_SOURCE_SELECT_BIT = 16;
	localparam int FASTWK_BIT = 24;
	localparam int WAKE_SRC_N = 6;
	localparam int PAD_N = 9;
	localparam logic [1:0] PS_DEFAULT = 2'h0;
	localparam logic [11:0] REVISION_NUM = 12'h001; // Arbitrary value
	localparam logic [3:0] VARIANT_NUM = 4'h0; // Arbitrary value

	typedef enum logic [1:0] {PM_RUN, PM_SLEEP, PM_RETAIN, PM_BACKUP} pmode_t;

	typedef struct packed {
		logic quick_wake_select;
		logic low_speed_source_select;
		logic [1:0] sleep_depth;
		logic retention_mode_select;
		logic backup_mode_select;
		logic scaling_change_request;
		logic [1:0] scaling_config_value;
	} power_mode_control_t;

	typedef struct packed {
		logic cpu;
		logic ahb;
		logic pb;
		logic generic_clocks;
		logic sources;
	} clk_stop_t;

	typedef struct packed {
		power_mode_control_t power_mode_control;
		logic [WAKE_SRC_N-1:0] wake_cause;
		logic [WAKE_SRC_N-1:0] wake_en;
		logic [PAD_N-1:0] pad_route;
		logic io_hold_bit;
		logic unlocked;
		logic access_err;
		pmode_t mode;
		logic [31:0] rdata;
		logic rvalid;
		clk_stop_t stop;
		logic io_hold;
		logic scale_start;
	} state_t;
endpackage : backup_power_pkg

// File: backup_power_mode_control.sv
// Power mode control, backup wake tracking, pad routing and I/O hold
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Low-speed source bit: 0 crystal oscillator, 1 low-speed RC oscillator.
// - Sleep depth 0 stops only the processor clock.
// - Sleep depth 1 stops processor and system bus clocks.
// - Sleep depth 2 also stops peripheral bus and generic clocks; sources run.
// - Sleep depth 3 also stops clock sources except system RC and 32kHz.
// - Retention mode chosen when retention bit, deep sleep set, backup bit clear.
// - Backup mode chosen when backup bit and deep sleep set.
// - Scaling request written 1 by software, cleared by hardware on completion.
// - Scaling configuration returns to default on backup exit.
// - Backup wake sets the cause bit of the waking source.
// - Wake cause is read-only and survives reset.
// - Wake enables gate sources out of backup; reset to zero.
// - Pad routing bits connect interrupt line n to its backup pad.
// - I/O hold bit holds lines after backup wake until written 0.
// - Quick wake bit selects fast analog wake unless flash high speed.
// - Revision register shows version and variant, read-only.
// - Locked write without unlock raises access error flag.
module backup_power_mode_control import backup_power_pkg::*; (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic bus_sel,
	input wire logic bus_write,
	input wire logic [ADDR_W-1:0] bus_addr,
	input wire logic [31:0] bus_wdata,
	output logic [31:0] bus_rdata,
	output logic bus_rvalid,
	input wire logic sleep_req,
	input wire logic processor_deep_sleep_bit,
	input wire logic wake_event,
	input wire logic [WAKE_SRC_N-1:0] wake_src,
	input wire logic scaling_done,
	input wire logic flash_high_speed,
	input wire logic [PAD_N-1:0] ext_irq_line,
	output logic [PAD_N-1:0] backup_pad_drive,
	output logic [PAD_N-1:0] backup_pad_enable,
	output clk_stop_t clk_stop,
	output pmode_t power_mode,
	output logic low_speed_source_select,
	output logic quick_wake_active,
	output logic scaling_start,
	output logic [1:0] scaling_config_value,
	output logic io_hold,
	output logic access_error
);
	state_t s_reg, s_next;
	logic acc;
	logic wr;
	logic [WAKE_SRC_N-1:0] gated;
	power_mode_control_t wpm;

	assign acc = bus_sel;
	assign wr = bus_sel & bus_write;
	assign gated = wake_src & s_reg.wake_en;
	assign wpm = '{quick_wake_select: bus_wdata[FASTWK_BIT],
		low_speed_source_select: bus_wdata[LOW_SPEED_SOURCE_SELECT_BIT],
		sleep_depth: bus_wdata[SLEEP_LSB+:2],
		retention_mode_select: bus_wdata[RET_BIT],
		backup_mode_select: bus_wdata[BACKUP_MODE_SELECT_BIT],
		scaling_change_request: bus_wdata[SCALING_CHANGE_REQUEST_BIT],
		scaling_config_value: bus_wdata[PS_LSB+:2]};

	always_comb begin
		s_next = s_reg;
		s_next.scale_start = 1'b0;
		s_next.rvalid = 1'b0;
		// Any access consumes a pending unlock
		if (acc) begin
			s_next.unlocked = 1'b0;
		end
		if (wr) begin
			case (bus_addr)
				OFF_UNLOCK: begin
					s_next.unlocked = (bus_wdata[KEY_LSB+:8] == UNLOCK_KEY)
						&& (bus_wdata[ADDR_W-1:0] == OFF_POWER_MODE_CONTROL);
				end
				OFF_POWER_MODE_CONTROL: begin
					if (s_reg.unlocked) begin
						s_next.power_mode_control = wpm;
						s_next.power_mode_control.scaling_change_request = wpm.scaling_change_request;
						s_next.scale_start = wpm.scaling_change_request;
					end else begin
						s_next.access_err = 1'b1;
					end
				end
				OFF_WAKE_EN: s_next.wake_en = bus_wdata[WAKE_SRC_N-1:0];
				OFF_PAD_ROUTE: s_next.pad_route = bus_wdata[PAD_N-1:0];
				OFF_IO_HOLD: begin
					s_next.io_hold_bit = bus_wdata[0];
					if (!bus_wdata[0]) begin
						s_next.io_hold = 1'b0;
					end
				end
				default: ;
			endcase
		end
		// Completion wins over a same-cycle software write
		if (scaling_done) begin
			s_next.power_mode_control.scaling_change_request = 1'b0;
		end
		if (acc && !bus_write) begin
			s_next.rvalid = 1'b1;
			case (bus_addr)
				OFF_STATUS: s_next.rdata = {s_reg.access_err, 31'h0};
				OFF_POWER_MODE_CONTROL: s_next.rdata = {7'h0, s_reg.power_mode_control.quick_wake_select,
					7'h0, s_reg.power_mode_control.low_speed_source_select,
					2'h0, s_reg.power_mode_control.sleep_depth, 2'h0,
					s_reg.power_mode_control.retention_mode_select, s_reg.power_mode_control.backup_mode_select,
					5'h0, s_reg.power_mode_control.scaling_change_request,
					s_reg.power_mode_control.scaling_config_value};
				OFF_WAKE_CAUSE: s_next.rdata = {26'h0, s_reg.wake_cause};
				OFF_WAKE_EN: s_next.rdata = {26'h0, s_reg.wake_en};
				OFF_PAD_ROUTE: s_next.rdata = {23'h0, s_reg.pad_route};
				OFF_IO_HOLD: s_next.rdata = {31'h0, s_reg.io_hold_bit};
				OFF_REVISION: s_next.rdata = {12'h0, VARIANT_NUM, 4'h0, REVISION_NUM};
				default: s_next.rdata = 32'h0;
			endcase
		end
		case (s_reg.mode)
			PM_RUN: begin
				if (sleep_req) begin
					if (processor_deep_sleep_bit && s_reg.power_mode_control.backup_mode_select) begin
						s_next.mode = PM_BACKUP;
					end else if (processor_deep_sleep_bit
						&& s_reg.power_mode_control.retention_mode_select) begin
						s_next.mode = PM_RETAIN;
					end else begin
						s_next.mode = PM_SLEEP;
					end
				end
			end
			PM_SLEEP, PM_RETAIN: begin
				if (wake_event) begin
					s_next.mode = PM_RUN;
				end
			end
			PM_BACKUP: begin
				if (|gated) begin
					s_next.mode = PM_RUN;
					s_next.wake_cause = gated;
					s_next.power_mode_control.scaling_config_value = PS_DEFAULT;
					s_next.io_hold = s_reg.io_hold_bit;
				end
			end
			default: s_next.mode = PM_RUN;
		endcase
		s_next.stop = '0;
		if (s_next.mode != PM_RUN) begin
			s_next.stop.cpu = 1'b1;
			s_next.stop.ahb = (s_reg.power_mode_control.sleep_depth >= 2'd1);
			s_next.stop.pb = (s_reg.power_mode_control.sleep_depth >= 2'd2);
			s_next.stop.generic_clocks = (s_reg.power_mode_control.sleep_depth >= 2'd2);
			s_next.stop.sources = (s_reg.power_mode_control.sleep_depth == 2'd3);
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			s_reg.power_mode_control <= '0;
			s_reg.wake_en <= '0;
			s_reg.pad_route <= '0;
			s_reg.io_hold_bit <= 1'b0;
			s_reg.unlocked <= 1'b0;
			s_reg.access_err <= 1'b0;
			s_reg.mode <= PM_RUN;
			s_reg.rdata <= '0;
			s_reg.rvalid <= 1'b0;
			s_reg.stop <= '0;
			s_reg.io_hold <= 1'b0;
			s_reg.scale_start <= 1'b0;
			s_reg.wake_cause <= s_next.wake_cause;
		end else begin
			s_reg <= s_next;
		end
	end

	// Pad drive is registered so every output leaves a flop
	logic [PAD_N-1:0] pad_drv_reg;
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			pad_drv_reg <= '0;
		end else begin
			pad_drv_reg <= ext_irq_line & s_reg.pad_route;
		end
	end

	logic quick_reg;
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			quick_reg <= 1'b0;
		end else begin
			quick_reg <= s_reg.power_mode_control.quick_wake_select & ~flash_high_speed;
		end
	end

	assign bus_rdata = s_reg.rdata;
	assign bus_rvalid = s_reg.rvalid;
	assign backup_pad_drive = pad_drv_reg;
	assign backup_pad_enable = s_reg.pad_route;
	assign clk_stop = s_reg.stop;
	assign power_mode = s_reg.mode;
	assign low_speed_source_select = s_reg.power_mode_control.low_speed_source_select;
	assign quick_wake_active = quick_reg;
	assign scaling_start = s_reg.scale_start;
	assign scaling_config_value = s_reg.power_mode_control.scaling_config_value;
	assign io_hold = s_reg.io_hold;
	assign access_error = s_reg.access_err;

	property p_err;
		@(posedge mclk) disable iff (sys_rst)
		(wr && bus_addr == OFF_POWER_MODE_CONTROL && !s_reg.unlocked) |=> access_error;
	endproperty
	a_err: assert property (p_err) else $error("locked write no error");
	property p_lock;
		@(posedge mclk) disable iff (sys_rst)
		(wr && bus_addr == OFF_POWER_MODE_CONTROL && !s_reg.unlocked) |=> $stable(s_reg.power_mode_control.sleep_depth);
	endproperty
	a_lock: assert property (p_lock) else $error("locked write changed control");
	property p_once;
		@(posedge mclk) disable iff (sys_rst) acc |=> !s_reg.unlocked || $past(wr);
	endproperty
	a_once: assert property (p_once) else $error("unlock outlived access");
	property p_backup_mode_select;
		@(posedge mclk) disable iff (sys_rst)
		(power_mode == PM_RUN && sleep_req && processor_deep_sleep_bit
			&& s_reg.power_mode_control.backup_mode_select) |=> power_mode == PM_BACKUP;
	endproperty
	a_backup_mode_select: assert property (p_backup_mode_select) else $error("backup not entered");
	property p_ret;
		@(posedge mclk) disable iff (sys_rst)
		(power_mode == PM_RUN && sleep_req && processor_deep_sleep_bit
			&& !s_reg.power_mode_control.backup_mode_select && s_reg.power_mode_control.retention_mode_select)
			|=> power_mode == PM_RETAIN;
	endproperty
	a_ret: assert property (p_ret) else $error("retention not entered");
	property p_cause;
		@(posedge mclk) disable iff (sys_rst)
		(power_mode == PM_BACKUP && |gated) |=> s_reg.wake_cause == $past(gated)
			&& scaling_config_value == PS_DEFAULT;
	endproperty
	a_cause: assert property (p_cause) else $error("wake cause wrong");
	property p_gate;
		@(posedge mclk) disable iff (sys_rst)
		(power_mode == PM_BACKUP && !(|(wake_src & s_reg.wake_en))) |=> power_mode == PM_BACKUP;
	endproperty
	a_gate: assert property (p_gate) else $error("blocked source woke");
	property p_done;
		@(posedge mclk) disable iff (sys_rst) scaling_done |=> !s_reg.power_mode_control.scaling_change_request;
	endproperty
	a_done: assert property (p_done) else $error("request not cleared");
	property p_stop;
		@(posedge mclk) disable iff (sys_rst)
		(power_mode != PM_RUN) |-> clk_stop.cpu && (clk_stop.sources -> clk_stop.pb);
	endproperty
	a_stop: assert property (p_stop) else $error("clock stop wrong");
	c_backup_mode_select: cover property (@(posedge mclk) power_mode == PM_BACKUP ##1 power_mode == PM_RUN);
	c_unl: cover property (@(posedge mclk) s_reg.unlocked ##1 wr && bus_addr == OFF_POWER_MODE_CONTROL);
	c_err: cover property (@(posedge mclk) $rose(access_error));
endmodule : backup_power_mode_control
`default_nettype wire

// File: scaling_responder.sv
// Far-side model of the regulator that finishes a power scaling change
`timescale 1ns/1ns
`default_nettype none
module scaling_responder #(parameter int DELAY = 8) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic scaling_start,
	output logic scaling_done
);
	int cnt = 0;
	// Never answers in the same cycle, so a lazy clear in the block shows up
	always @(posedge mclk) begin
		scaling_done <= !sys_rst && cnt == 1;
		if (sys_rst) cnt <= 0;
		else if (scaling_start) cnt <= DELAY;
		else if (cnt > 0) cnt <= cnt - 1;
	end
endmodule : scaling_responder
`default_nettype wire

// File: backup_power_mode_control_tb.sv
// Self-checking bench for the backup power mode control block
`timescale 1ns/1ns
`default_nettype none
module backup_power_mode_control_tb import backup_power_pkg::*; ;
	logic mclk = 0, sys_rst = 1, bus_sel = 0, bus_write = 0, sleep_req = 0;
	logic processor_deep_sleep_bit = 0, wake_event = 0, flash_high_speed = 0;
	logic [ADDR_W-1:0] bus_addr = 0;
	logic [31:0] bus_wdata = 0, bus_rdata, rd;
	logic bus_rvalid, scaling_done, low_speed_source_select, quick_wake_active;
	logic scaling_start, io_hold, access_error;
	logic [WAKE_SRC_N-1:0] wake_src = 0;
	logic [PAD_N-1:0] ext_irq_line = 0, backup_pad_drive, backup_pad_enable;
	logic [1:0] scaling_config_value;
	clk_stop_t clk_stop;
	pmode_t power_mode;
	int fail_count = 0, checked = 0;

	backup_power_mode_control uut (.mclk, .sys_rst, .bus_sel, .bus_write, .bus_addr,
		.bus_wdata, .bus_rdata, .bus_rvalid, .sleep_req, .processor_deep_sleep_bit,
		.wake_event, .wake_src, .scaling_done, .flash_high_speed, .ext_irq_line,
		.backup_pad_drive, .backup_pad_enable, .clk_stop, .power_mode,
		.low_speed_source_select, .quick_wake_active, .scaling_start,
		.scaling_config_value, .io_hold, .access_error);
	scaling_responder #(.DELAY(8)) model (.mclk, .sys_rst, .scaling_start, .scaling_done);

	always #2 mclk = ~mclk;

	task tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : tick
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge mclk);
		#1;
		bus_sel = 1;
		bus_write = w;
		bus_addr = a;
		bus_wdata = d;
		tick(1);
		bus_sel = 0;
		rd = bus_rdata;
		if (!w) chk(bus_rvalid, 1);
	endtask : bus
	task rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
		bus(0, a, 32'h0);
		chk(rd, exp);
	endtask : rdchk
	// Key and target address, then the control write as the very next access
	task uw(input logic [31:0] d);
		bus(1, OFF_UNLOCK, {UNLOCK_KEY, 14'h0, OFF_POWER_MODE_CONTROL});
		bus(1, OFF_POWER_MODE_CONTROL, d);
	endtask : uw
	task nap;
		sleep_req = 1;
		tick(1);
		sleep_req = 0;
		tick(2);
	endtask : nap
	task rouse;
		wake_event = 1;
		tick(1);
		wake_event = 0;
		tick(2);
	endtask : rouse

	task t_regs;
		rdchk(OFF_WAKE_EN, 32'h0);
		rdchk(OFF_PAD_ROUTE, 32'h0);
		rdchk(OFF_IO_HOLD, 32'h0);
		rdchk(OFF_POWER_MODE_CONTROL, 32'h0);
		bus(1, OFF_REVISION, 32'hffffffff);
		rdchk(OFF_REVISION, {12'h0, VARIANT_NUM, 4'h0, REVISION_NUM});
		rdchk(10'h100, 32'h0);
		chk(access_error, 0);
	endtask : t_regs
	task t_lock;
		uw(32'h01010000);
		tick(2);
		chk(low_speed_source_select, 1);
		chk(quick_wake_active, 1);
		flash_high_speed = 1;
		tick(2);
		chk(quick_wake_active, 0);
		flash_high_speed = 0;
		bus(1, OFF_POWER_MODE_CONTROL, 32'h0);
		tick(1);
		chk(low_speed_source_select, 1);
		chk(access_error, 1);
		bus(0, OFF_STATUS, 32'h0);
		chk(rd[ERR_BIT], 1);
		bus(1, OFF_UNLOCK, {UNLOCK_KEY, 14'h0, OFF_POWER_MODE_CONTROL});
		bus(0, OFF_WAKE_EN, 32'h0);
		bus(1, OFF_POWER_MODE_CONTROL, 32'h0);
		chk(low_speed_source_select, 1);
		uw(32'h0);
		tick(1);
		chk(low_speed_source_select, 0);
	endtask : t_lock
	task t_sleep;
		logic [4:0] stops [4];
		stops = '{5'h10, 5'h18, 5'h1e, 5'h1f};
		for (int d = 0; d < 4; d++) begin
			uw(d << SLEEP_LSB);
			nap();
			chk(power_mode, PM_SLEEP);
			chk(clk_stop, stops[d]);
			rouse();
			chk(clk_stop, 5'h0);
		end
		uw(32'h200);
		processor_deep_sleep_bit = 1;
		nap();
		chk(power_mode, PM_RETAIN);
		rouse();
		chk(power_mode, PM_RUN);
	endtask : t_sleep
	task t_backup;
		uw(32'h303);
		chk(scaling_start, 0);
		tick(1);
		chk(scaling_config_value, 2'h3);
		bus(1, OFF_WAKE_EN, 32'hffffffc4);
		rdchk(OFF_WAKE_EN, 32'h4);
		bus(1, OFF_IO_HOLD, 32'hffffffff);
		rdchk(OFF_IO_HOLD, 32'h1);
		nap();
		chk(power_mode, PM_BACKUP);
		wake_src = 6'h3b;
		tick(3);
		chk(power_mode, PM_BACKUP);
		wake_src = 6'h04;
		tick(3);
		wake_src = 6'h0;
		chk(power_mode, PM_RUN);
		chk(scaling_config_value, PS_DEFAULT);
		chk(io_hold, 1);
		bus(1, OFF_WAKE_CAUSE, 32'h0);
		rdchk(OFF_WAKE_CAUSE, 32'h4);
		bus(1, OFF_IO_HOLD, 32'h0);
		tick(1);
		chk(io_hold, 0);
		processor_deep_sleep_bit = 0;
	endtask : t_backup
	task t_scale;
		uw(32'h5);
		chk(scaling_start, 1);
		rdchk(OFF_POWER_MODE_CONTROL, 32'h5);
		chk(scaling_start, 0);
		tick(12);
		rdchk(OFF_POWER_MODE_CONTROL, 32'h1);
	endtask : t_scale
	task t_pads;
		bus(1, OFF_PAD_ROUTE, 32'hffffffff);
		rdchk(OFF_PAD_ROUTE, 32'h1ff);
		chk(backup_pad_enable, 9'h1ff);
		ext_irq_line = 9'h0a5;
		tick(2);
		chk(backup_pad_drive, 9'h0a5);
		bus(1, OFF_PAD_ROUTE, 32'h3);
		tick(2);
		chk(backup_pad_drive, 9'h001);
	endtask : t_pads
	task t_reset;
		sys_rst = 1;
		tick(4);
		sys_rst = 0;
		rdchk(OFF_WAKE_CAUSE, 32'h4);
		rdchk(OFF_WAKE_EN, 32'h0);
		chk(access_error, 0);
	endtask : t_reset

	task test_done;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : test_done

	initial begin
		tick(16);
		sys_rst = 0;
		t_regs();
		t_lock();
		t_sleep();
		t_backup();
		t_scale();
		t_pads();
		t_reset();
		test_done();
	end
	// The whole sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge mclk);
		fail_count++;
		test_done();
	end
endmodule : backup_power_mode_control_tb
`default_nettype wire
